// file: logic/hmgc_top.sv
// Chosen here: the Avalon-MM interface to the registers.
`default_nettype none
// Mixer input gains and first headphone pair controls behind an Avalon-MM slave.
module hmgc_top (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [9:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic hp_left_sign,
  input wire logic hp_right_sign,
  output logic [2:0] lin_amp_to_lmix_gain,
  output logic [2:0] rin_amp_to_lmix_gain,
  output logic [2:0] laux_to_lmix_gain,
  output logic [2:0] lin_amp_to_rmix_gain,
  output logic [2:0] rin_amp_to_rmix_gain,
  output logic [2:0] raux_to_rmix_gain,
  output logic lin_amp_to_lmix_on,
  output logic rin_amp_to_lmix_on,
  output logic laux_to_lmix_on,
  output logic lin_amp_to_rmix_on,
  output logic rin_amp_to_rmix_on,
  output logic raux_to_rmix_on,
  output logic [5:0] hp_left_level,
  output logic [5:0] hp_right_level,
  output logic hp_left_silence,
  output logic hp_right_silence,
  output logic hp_left_on,
  output logic hp_right_on,
  output logic hp_ground_feedback_enable
);
  // Bus handshake state.
  logic ack_r; // High in the cycle a request completes.
  logic ack_nxt;
  logic [31:0] rdata_r; // Read word captured in the first request cycle.
  logic [31:0] rdata_nxt;
  logic [15:0] rd_word; // Combinational readback of the addressed register.
  logic wr_go; // Write takes effect at this edge.
  logic we_lo; // Low byte lane write.
  logic we_hi; // High byte lane write.
  // Address decode.
  logic sel_oc;
  logic sel_lmix;
  logic sel_rmix;
  logic sel_hpl;
  logic sel_hpr;
  logic sel_pwr;
  // Control bits held here.
  logic fb_r;
  logic fb_nxt;
  logic on_l_r;
  logic on_l_nxt;
  logic on_r_r;
  logic on_r_nxt;
  logic mute_l_r;
  logic mute_l_nxt;
  logic mute_r_r;
  logic mute_r_nxt;
  logic zc_l_r;
  logic zc_l_nxt;
  logic zc_r_r;
  logic zc_r_nxt;
  logic [5:0] stage_l_r; // Written volume, not yet committed.
  logic [5:0] stage_l_nxt;
  logic [5:0] stage_r_r;
  logic [5:0] stage_r_nxt;
  logic commit_req; // Pulse: one written to the commit bit.
  logic pend_l;
  logic pend_r;

  // Register decode uses the word index; the low address bits are ignored.
  assign sel_oc = (address[9:2] == hmgc_pkg::IDX_OUT_CTRL);
  assign sel_lmix = (address[9:2] == hmgc_pkg::IDX_LMIX);
  assign sel_rmix = (address[9:2] == hmgc_pkg::IDX_RMIX);
  assign sel_hpl = (address[9:2] == hmgc_pkg::IDX_HP_L);
  assign sel_hpr = (address[9:2] == hmgc_pkg::IDX_HP_R);
  assign sel_pwr = (address[9:2] == hmgc_pkg::IDX_PWR);

  // Every access waits exactly one cycle; this keeps read data registered.
  assign waitrequest = (read || write) && !ack_r;
  assign wr_go = write && ack_r;
  assign we_lo = wr_go && byteenable[hmgc_pkg::BE_LO];
  assign we_hi = wr_go && byteenable[hmgc_pkg::BE_HI];
  assign readdata = rdata_r;

  // Readback of the addressed register; unmapped words read zero.
  always_comb begin
    rd_word = 16'h0000;
    case (address[9:2])
      hmgc_pkg::IDX_OUT_CTRL: begin
        rd_word[hmgc_pkg::FB_BIT] = fb_r;
      end
      hmgc_pkg::IDX_LMIX: begin
        rd_word[hmgc_pkg::MIX_LIN_LSB +: hmgc_pkg::MIX_W] = lin_amp_to_lmix_gain;
        rd_word[hmgc_pkg::MIX_RIN_LSB +: hmgc_pkg::MIX_W] = rin_amp_to_lmix_gain;
        rd_word[hmgc_pkg::LMIX_AUX_LSB +: hmgc_pkg::MIX_W] = laux_to_lmix_gain;
      end
      hmgc_pkg::IDX_RMIX: begin
        rd_word[hmgc_pkg::MIX_LIN_LSB +: hmgc_pkg::MIX_W] = lin_amp_to_rmix_gain;
        rd_word[hmgc_pkg::MIX_RIN_LSB +: hmgc_pkg::MIX_W] = rin_amp_to_rmix_gain;
        rd_word[hmgc_pkg::RMIX_AUX_LSB +: hmgc_pkg::MIX_W] = raux_to_rmix_gain;
      end
      hmgc_pkg::IDX_HP_L: begin
        // The commit bit is never stored, so it reads zero.
        rd_word[hmgc_pkg::VOL_LSB +: hmgc_pkg::VOL_W] = stage_l_r;
        rd_word[hmgc_pkg::ZC_BIT] = zc_l_r;
        rd_word[hmgc_pkg::MUTE_BIT] = mute_l_r;
        rd_word[hmgc_pkg::ON_BIT] = on_l_r;
      end
      hmgc_pkg::IDX_HP_R: begin
        rd_word[hmgc_pkg::VOL_LSB +: hmgc_pkg::VOL_W] = stage_r_r;
        rd_word[hmgc_pkg::ZC_BIT] = zc_r_r;
        rd_word[hmgc_pkg::MUTE_BIT] = mute_r_r;
        rd_word[hmgc_pkg::ON_BIT] = on_r_r;
      end
      hmgc_pkg::IDX_PWR: begin
        rd_word[hmgc_pkg::PWR_L_BIT] = on_l_r;
        rd_word[hmgc_pkg::PWR_R_BIT] = on_r_r;
      end
      default: begin
        rd_word = 16'h0000;
      end
    endcase
  end

  // Bus handshake next state.
  always_comb begin
    ack_nxt = (read || write) && !ack_r;
    rdata_nxt = rdata_r;
    if (read && !ack_r) begin
      rdata_nxt = {16'h0000, rd_word};
    end
  end

  // Bus handshake registers.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Next values of the headphone and output control bits.
  always_comb begin
    fb_nxt = fb_r;
    on_l_nxt = on_l_r;
    on_r_nxt = on_r_r;
    mute_l_nxt = mute_l_r;
    mute_r_nxt = mute_r_r;
    zc_l_nxt = zc_l_r;
    zc_r_nxt = zc_r_r;
    stage_l_nxt = stage_l_r;
    stage_r_nxt = stage_r_r;
    if (we_lo && sel_oc) begin
      fb_nxt = writedata[hmgc_pkg::FB_BIT];
    end
    if (we_lo && sel_hpl) begin
      stage_l_nxt = writedata[hmgc_pkg::VOL_LSB +: hmgc_pkg::VOL_W];
    end
    if (we_lo && sel_hpr) begin
      stage_r_nxt = writedata[hmgc_pkg::VOL_LSB +: hmgc_pkg::VOL_W];
    end
    if (we_hi && sel_hpl) begin
      zc_l_nxt = writedata[hmgc_pkg::ZC_BIT];
      mute_l_nxt = writedata[hmgc_pkg::MUTE_BIT];
      on_l_nxt = writedata[hmgc_pkg::ON_BIT];
    end
    if (we_hi && sel_hpr) begin
      zc_r_nxt = writedata[hmgc_pkg::ZC_BIT];
      mute_r_nxt = writedata[hmgc_pkg::MUTE_BIT];
      on_r_nxt = writedata[hmgc_pkg::ON_BIT];
    end
    if (we_lo && sel_pwr) begin
      on_l_nxt = writedata[hmgc_pkg::PWR_L_BIT];
      on_r_nxt = writedata[hmgc_pkg::PWR_R_BIT];
    end
  end

  assign commit_req = we_hi && (sel_hpl || sel_hpr) && writedata[hmgc_pkg::COMMIT_BIT];

  // Control registers; staged volume resets to 0dB.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      fb_r <= 1'b0;
      on_l_r <= 1'b0;
      on_r_r <= 1'b0;
      mute_l_r <= 1'b0;
      mute_r_r <= 1'b0;
      zc_l_r <= 1'b0;
      zc_r_r <= 1'b0;
      stage_l_r <= hmgc_pkg::VOL_RST;
      stage_r_r <= hmgc_pkg::VOL_RST;
    end else begin
      fb_r <= fb_nxt;
      on_l_r <= on_l_nxt;
      on_r_r <= on_r_nxt;
      mute_l_r <= mute_l_nxt;
      mute_r_r <= mute_r_nxt;
      zc_l_r <= zc_l_nxt;
      zc_r_r <= zc_r_nxt;
      stage_l_r <= stage_l_nxt;
      stage_r_r <= stage_r_nxt;
    end
  end

  assign hp_ground_feedback_enable = fb_r;
  assign hp_left_on = on_l_r;
  assign hp_right_on = on_r_r;
  assign hp_left_silence = mute_l_r;
  assign hp_right_silence = mute_r_r;

  // The channels see this cycle's written values so one write can stage and commit.
  hmgc_hp_channel u_hp_left (
    .clk(clk),
    .rst_b(rst_b),
    .commit(commit_req),
    .zc_gate(zc_l_nxt),
    .staged(stage_l_nxt),
    .sign_pin(hp_left_sign),
    .level(hp_left_level),
    .pending(pend_l)
  );

  hmgc_hp_channel u_hp_right (
    .clk(clk),
    .rst_b(rst_b),
    .commit(commit_req),
    .zc_gate(zc_r_nxt),
    .staged(stage_r_nxt),
    .sign_pin(hp_right_sign),
    .level(hp_right_level),
    .pending(pend_r)
  );

  hmgc_mix_path u_lmix_lin (
    .clk(clk),
    .rst_b(rst_b),
    .wr_en(we_lo && sel_lmix),
    .wr_code(writedata[hmgc_pkg::MIX_LIN_LSB +: hmgc_pkg::MIX_W]),
    .gain_code(lin_amp_to_lmix_gain),
    .path_on(lin_amp_to_lmix_on)
  );

  hmgc_mix_path u_lmix_rin (
    .clk(clk),
    .rst_b(rst_b),
    .wr_en(we_lo && sel_lmix),
    .wr_code(writedata[hmgc_pkg::MIX_RIN_LSB +: hmgc_pkg::MIX_W]),
    .gain_code(rin_amp_to_lmix_gain),
    .path_on(rin_amp_to_lmix_on)
  );

  hmgc_mix_path u_lmix_aux (
    .clk(clk),
    .rst_b(rst_b),
    .wr_en(we_hi && sel_lmix),
    .wr_code(writedata[hmgc_pkg::LMIX_AUX_LSB +: hmgc_pkg::MIX_W]),
    .gain_code(laux_to_lmix_gain),
    .path_on(laux_to_lmix_on)
  );

  hmgc_mix_path u_rmix_lin (
    .clk(clk),
    .rst_b(rst_b),
    .wr_en(we_lo && sel_rmix),
    .wr_code(writedata[hmgc_pkg::MIX_LIN_LSB +: hmgc_pkg::MIX_W]),
    .gain_code(lin_amp_to_rmix_gain),
    .path_on(lin_amp_to_rmix_on)
  );

  hmgc_mix_path u_rmix_rin (
    .clk(clk),
    .rst_b(rst_b),
    .wr_en(we_lo && sel_rmix),
    .wr_code(writedata[hmgc_pkg::MIX_RIN_LSB +: hmgc_pkg::MIX_W]),
    .gain_code(rin_amp_to_rmix_gain),
    .path_on(rin_amp_to_rmix_on)
  );

  hmgc_mix_path u_rmix_aux (
    .clk(clk),
    .rst_b(rst_b),
    .wr_en(we_hi && sel_rmix),
    .wr_code(writedata[hmgc_pkg::RMIX_AUX_LSB +: hmgc_pkg::MIX_W]),
    .gain_code(raux_to_rmix_gain),
    .path_on(raux_to_rmix_on)
  );

  a_lmix_aux_map: assert property (@(posedge clk) disable iff (!rst_b)
    we_hi && sel_lmix |=> laux_to_lmix_gain == $past(writedata[11:9])) else $error("Left aux field misplaced.");
  a_rmix_aux_map: assert property (@(posedge clk) disable iff (!rst_b)
    we_hi && sel_rmix |=> raux_to_rmix_gain == $past(writedata[15:13])) else $error("Right aux field misplaced.");
  a_hp_reset_level: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(rst_b) |-> hp_left_level == hmgc_pkg::VOL_RST && hp_right_level == hmgc_pkg::VOL_RST)
    else $error("Volume not 0dB after reset.");
  a_hold_no_commit: assert property (@(posedge clk) disable iff (!rst_b)
    we_lo && sel_hpl && !commit_req && !pend_l |=> $stable(hp_left_level)) else $error("Volume applied without commit.");
  a_commit_both: assert property (@(posedge clk) disable iff (!rst_b)
    commit_req && !zc_l_nxt && !zc_r_nxt |=> hp_left_level == stage_l_r && hp_right_level == stage_r_r &&
    !pend_l && !pend_r) else $error("Commit did not move both channels.");
  a_mute_follows: assert property (@(posedge clk) disable iff (!rst_b)
    we_hi && sel_hpr |=> hp_right_silence == $past(writedata[hmgc_pkg::MUTE_BIT])) else $error("Mute bit not applied.");
  a_fb_follows: assert property (@(posedge clk) disable iff (!rst_b)
    we_lo && sel_oc |=> hp_ground_feedback_enable == $past(writedata[hmgc_pkg::FB_BIT]))
    else $error("Feedback bit not applied.");
  a_shared_enable: assert property (@(posedge clk) disable iff (!rst_b)
    read && !ack_r && sel_pwr |=> readdata[hmgc_pkg::PWR_L_BIT] == hp_left_on &&
    readdata[hmgc_pkg::PWR_R_BIT] == hp_right_on) else $error("Enable views disagree.");
  a_commit_reads_zero: assert property (@(posedge clk) disable iff (!rst_b)
    read && ack_r && (sel_hpl || sel_hpr) |-> !readdata[hmgc_pkg::COMMIT_BIT]) else $error("Commit bit read as one.");
endmodule : hmgc_top
`default_nettype wire

// file: common/hmgc_pkg.sv
// Function
// - Zero mixer gain code disconnects the path.
// - Nonzero mixer code selects path gain.
// - Left mixer fields at 3:1, 7:5, 11:9.
// - Right mixer fields at 3:1, 7:5, 15:13.
// - Mixer gain fields reset to zero.
// - Headphone volume bits 7:2, reset 0dB.
// - Volumes staged until commit bit written.
// - Zero-cross bit 13 gates gain changes.
// - Bit 14 mutes the headphone output.
// - Output control bit 0 enables ground feedback.
// - Output enable shared with power register.
`default_nettype none
package hmgc_pkg;
  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IDX_OUT_CTRL = 8'h4c;
  localparam logic [7:0] IDX_LMIX = 8'h60;
  localparam logic [7:0] IDX_RMIX = 8'h61;
  localparam logic [7:0] IDX_HP_L = 8'h68;
  localparam logic [7:0] IDX_HP_R = 8'h69;
  localparam logic [7:0] IDX_PWR = 8'h0a;
  // Byte lanes that carry the 16-bit registers.
  localparam int BE_LO = 0;
  localparam int BE_HI = 1;
  // Mixer path gain fields.
  localparam int MIX_W = 3;
  localparam int MIX_LIN_LSB = 1;
  localparam int MIX_RIN_LSB = 5;
  localparam int LMIX_AUX_LSB = 9;
  localparam int RMIX_AUX_LSB = 13;
  localparam logic [2:0] MIX_OFF = 3'h0;
  // Headphone volume register fields.
  localparam int VOL_W = 6;
  localparam int VOL_LSB = 2;
  localparam int COMMIT_BIT = 8;
  localparam int ZC_BIT = 13;
  localparam int MUTE_BIT = 14;
  localparam int ON_BIT = 15;
  localparam logic [5:0] VOL_RST = 6'h39;
  // Output control and power management bits.
  localparam int FB_BIT = 0;
  localparam int PWR_L_BIT = 0;
  localparam int PWR_R_BIT = 1;
endpackage : hmgc_pkg
`default_nettype wire

// file: logic/hmgc_mix_path.sv
`default_nettype none
// One mixer input path: holds its gain code and the path connect level.
module hmgc_mix_path (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wr_en,
  input wire logic [2:0] wr_code,
  output logic [2:0] gain_code,
  output logic path_on
);
  logic [2:0] code_r; // Stored gain code.
  logic [2:0] code_nxt;
  logic on_r; // Registered so the analogue switch sees no decode glitch.
  logic on_nxt;

  // Next code and connect level; zero code opens the path.
  always_comb begin
    code_nxt = code_r;
    on_nxt = on_r;
    if (wr_en) begin
      code_nxt = wr_code;
      on_nxt = (wr_code != hmgc_pkg::MIX_OFF);
    end
  end

  // Registers; paths start disconnected.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      code_r <= hmgc_pkg::MIX_OFF;
      on_r <= 1'b0;
    end else begin
      code_r <= code_nxt;
      on_r <= on_nxt;
    end
  end

  assign gain_code = code_r;
  assign path_on = on_r;

  a_mix_zero_off: assert property (@(posedge clk) disable iff (!rst_b)
    wr_en && wr_code == hmgc_pkg::MIX_OFF |=> !path_on) else $error("Zero code left path connected.");
  a_mix_code_pass: assert property (@(posedge clk) disable iff (!rst_b)
    wr_en |=> gain_code == $past(wr_code) && path_on == ($past(wr_code) != hmgc_pkg::MIX_OFF))
    else $error("Mixer gain code not applied.");
  a_mix_reset_off: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(rst_b) |-> gain_code == hmgc_pkg::MIX_OFF && !path_on) else $error("Mixer path not off after reset.");
endmodule : hmgc_mix_path
`default_nettype wire

// file: logic/hmgc_hp_channel.sv
`default_nettype none
// One headphone channel: active gain, commit target and zero-cross gating.
module hmgc_hp_channel (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic commit,
  input wire logic zc_gate,
  input wire logic [5:0] staged,
  input wire logic sign_pin,
  output logic [5:0] level,
  output logic pending
);
  logic [2:0] sync_r; // Bit 0 is the first synchroniser stage.
  logic [2:0] sync_nxt;
  logic sign_r; // Filtered signal polarity.
  logic sign_nxt;
  logic [5:0] level_r;
  logic [5:0] level_nxt;
  logic [5:0] target_r; // Gain waiting for a zero crossing.
  logic [5:0] target_nxt;
  logic pend_r;
  logic pend_nxt;
  logic zc_evt; // One-cycle pulse on an accepted polarity change.

  // Polarity filter and gain update.
  always_comb begin
    sync_nxt = {sync_r[1:0], sign_pin};
    // A change counts once the second and third stages agree.
    zc_evt = (sync_r[1] == sync_r[2]) && (sync_r[2] != sign_r);
    sign_nxt = zc_evt ? sync_r[2] : sign_r;
    level_nxt = level_r;
    target_nxt = target_r;
    pend_nxt = pend_r;
    if (commit) begin
      target_nxt = staged;
      if (zc_gate) begin
        // A new commit wins over a crossing in the same cycle.
        pend_nxt = 1'b1;
      end else begin
        level_nxt = staged;
        pend_nxt = 1'b0;
      end
    end else if (pend_r && (zc_evt || !zc_gate)) begin
      // apply at crossing; dropping the gate also releases the wait.
      level_nxt = target_r;
      pend_nxt = 1'b0;
    end
  end

  // Registers; gain resets to 0dB.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sync_r <= 3'h0;
      sign_r <= 1'b0;
      level_r <= hmgc_pkg::VOL_RST;
      target_r <= hmgc_pkg::VOL_RST;
      pend_r <= 1'b0;
    end else begin
      sync_r <= sync_nxt;
      sign_r <= sign_nxt;
      level_r <= level_nxt;
      target_r <= target_nxt;
      pend_r <= pend_nxt;
    end
  end

  assign level = level_r;
  assign pending = pend_r;

  a_zc_immediate: assert property (@(posedge clk) disable iff (!rst_b)
    commit && !zc_gate |=> level == $past(staged) && !pending) else $error("Ungated change not immediate.");
  a_zc_waits: assert property (@(posedge clk) disable iff (!rst_b)
    commit && zc_gate |=> pending && $stable(level)) else $error("Gated change applied early.");
  a_zc_applies: assert property (@(posedge clk) disable iff (!rst_b)
    pending && zc_evt && !commit |=> level == $past(target_r) && !pending) else $error("Crossing did not apply gain.");
endmodule : hmgc_hp_channel
`default_nettype wire

// file: verif/hmgc_testbench.sv
`default_nettype none
// Register-level bench for the mixer gain and headphone control block.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // Clock and synchronous active-low reset.
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  // Avalon-MM signals; the bench drives the request, the slave drives readdata and waitrequest.
  logic [9:0] address = 10'h000;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h00000000;
  logic [3:0] byteenable = 4'h0;
  logic [31:0] readdata;
  logic waitrequest;
  // Polarity inputs; a change marks a zero crossing.
  logic hp_left_sign = 1'b0;
  logic hp_right_sign = 1'b0;
  // Analogue control outputs of the block.
  logic [2:0] lin_amp_to_lmix_gain, rin_amp_to_lmix_gain, laux_to_lmix_gain;
  logic [2:0] lin_amp_to_rmix_gain, rin_amp_to_rmix_gain, raux_to_rmix_gain;
  logic lin_amp_to_lmix_on, rin_amp_to_lmix_on, laux_to_lmix_on;
  logic lin_amp_to_rmix_on, rin_amp_to_rmix_on, raux_to_rmix_on;
  logic [5:0] hp_left_level, hp_right_level;
  logic hp_left_silence, hp_right_silence, hp_left_on, hp_right_on;
  logic hp_ground_feedback_enable;
  // Verdict counters and the hang guard.
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  // Last read data taken at the acknowledging edge.
  logic [31:0] rd;
  // Zero comes last so a disconnect is seen after a live setting.
  logic [2:0] codes [4] = '{3'h7, 3'h1, 3'h2, 3'h0};

  // Free-running 40 MHz clock.
  always #12.5 clk = ~clk;

  hmgc_top uut (
    .clk, .rst_b, .address, .read, .write, .writedata, .byteenable, .readdata, .waitrequest,
    .hp_left_sign, .hp_right_sign,
    .lin_amp_to_lmix_gain, .rin_amp_to_lmix_gain, .laux_to_lmix_gain,
    .lin_amp_to_rmix_gain, .rin_amp_to_rmix_gain, .raux_to_rmix_gain,
    .lin_amp_to_lmix_on, .rin_amp_to_lmix_on, .laux_to_lmix_on,
    .lin_amp_to_rmix_on, .rin_amp_to_rmix_on, .raux_to_rmix_on,
    .hp_left_level, .hp_right_level, .hp_left_silence, .hp_right_silence,
    .hp_left_on, .hp_right_on, .hp_ground_feedback_enable
  );

  // Prints the verdict and ends the run; the only exit point.
  task automatic wrap_up();
    if (mismatches == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up

  // Compares a register word.
  task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected register at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask : check_reg

  // Compares a group of control outputs packed into one vector.
  task automatic check_pin(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected outputs at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask : check_pin

  // Waits for waitrequest low; a slave that never answers ends the run.
  task automatic wait_ack();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 64);
    if (waitrequest !== 1'b0) begin
      mismatches++;
      wrap_up();
    end
  endtask : wait_ack

  // One Avalon write; request held until the acknowledging edge.
  task automatic bus_write(input logic [7:0] idx, input logic [15:0] data, input logic [3:0] be);
    @(posedge clk);
    address <= {idx, 2'b00};
    writedata <= {16'h0000, data};
    byteenable <= be;
    write <= 1'b1;
    wait_ack();
    write <= 1'b0;
  endtask : bus_write

  // One Avalon read compared with an expected word.
  task automatic reg_chk(input logic [7:0] idx, input logic [31:0] exp);
    @(posedge clk);
    address <= {idx, 2'b00};
    byteenable <= 4'hf;
    read <= 1'b1;
    wait_ack();
    rd = readdata;
    read <= 1'b0;
    check_reg(rd, exp);
  endtask : reg_chk

  // Lets the registered outputs of the last write settle.
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
  endtask : settle

  // Cuts a hung run short; the tests need well under 2000 cycles.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      wrap_up();
    end
  end

  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    check_pin({6'h00, lin_amp_to_lmix_gain, rin_amp_to_lmix_gain, laux_to_lmix_gain,
               lin_amp_to_rmix_gain, rin_amp_to_rmix_gain, raux_to_rmix_gain}, 24'h000000);
    check_pin({12'h000, hp_left_level, hp_right_level}, {12'h000, 6'h39, 6'h39});
    check_pin({19'h00000, hp_left_silence, hp_right_silence, hp_left_on, hp_right_on,
               hp_ground_feedback_enable}, 24'h000000);
    reg_chk(hmgc_pkg::IDX_LMIX, 32'h00000000);
    reg_chk(hmgc_pkg::IDX_RMIX, 32'h00000000);
    reg_chk(hmgc_pkg::IDX_HP_L, 32'h000000e4);
    reg_chk(hmgc_pkg::IDX_HP_R, 32'h000000e4);
    reg_chk(hmgc_pkg::IDX_OUT_CTRL, 32'h00000000);
    // mixer gain codes and field places.
    foreach (codes[i]) begin
      bus_write(hmgc_pkg::IDX_LMIX, {4'h0, codes[i], 1'b0, codes[i], 1'b0, codes[i], 1'b0}, 4'h3);
      bus_write(hmgc_pkg::IDX_RMIX, {codes[i], 5'h00, codes[i], 1'b0, codes[i], 1'b0}, 4'h3);
      settle(2);
      check_pin({6'h00, lin_amp_to_lmix_gain, rin_amp_to_lmix_gain, laux_to_lmix_gain,
                 lin_amp_to_rmix_gain, rin_amp_to_rmix_gain, raux_to_rmix_gain},
                {6'h00, {6{codes[i]}}});
      check_pin({18'h00000, lin_amp_to_lmix_on, rin_amp_to_lmix_on, laux_to_lmix_on,
                 lin_amp_to_rmix_on, rin_amp_to_rmix_on, raux_to_rmix_on},
                {18'h00000, {6{codes[i] != 3'h0}}});
      reg_chk(hmgc_pkg::IDX_LMIX, {20'h00000, codes[i], 1'b0, codes[i], 1'b0, codes[i], 1'b0});
      reg_chk(hmgc_pkg::IDX_RMIX, {16'h0000, codes[i], 5'h00, codes[i], 1'b0, codes[i], 1'b0});
    end
    // upper byte lane alone reaches only the auxiliary field.
    bus_write(hmgc_pkg::IDX_LMIX, 16'hffff, 4'h2);
    settle(2);
    check_pin({15'h0000, lin_amp_to_lmix_gain, rin_amp_to_lmix_gain, laux_to_lmix_gain},
              {15'h0000, 3'h0, 3'h0, 3'h7});
    // writes stay staged until a commit.
    bus_write(hmgc_pkg::IDX_HP_L, 16'h0040, 4'h3);
    settle(2);
    check_pin({12'h000, hp_left_level, hp_right_level}, {12'h000, 6'h39, 6'h39});
    reg_chk(hmgc_pkg::IDX_HP_L, 32'h00000040);
    bus_write(hmgc_pkg::IDX_HP_R, 16'h01fc, 4'h3);
    settle(2);
    check_pin({12'h000, hp_left_level, hp_right_level}, {12'h000, 6'h10, 6'h3f});
    reg_chk(hmgc_pkg::IDX_HP_R, 32'h000000fc);
    // left gated by zero cross, right immediate.
    bus_write(hmgc_pkg::IDX_HP_L, 16'h2014, 4'h3);
    bus_write(hmgc_pkg::IDX_HP_R, 16'h0100, 4'h3);
    settle(6);
    check_pin({12'h000, hp_left_level, hp_right_level}, {12'h000, 6'h10, 6'h00});
    @(posedge clk);
    hp_left_sign <= 1'b1;
    settle(10);
    check_pin({12'h000, hp_left_level, hp_right_level}, {12'h000, 6'h05, 6'h00});
    bus_write(hmgc_pkg::IDX_HP_L, 16'h4014, 4'h3);
    bus_write(hmgc_pkg::IDX_HP_R, 16'h4000, 4'h3);
    settle(2);
    check_pin({22'h000000, hp_left_silence, hp_right_silence}, 24'h000003);
    // enable bits shared with the power register.
    bus_write(hmgc_pkg::IDX_PWR, 16'h0001, 4'h3);
    settle(2);
    check_pin({22'h000000, hp_left_on, hp_right_on}, 24'h000002);
    reg_chk(hmgc_pkg::IDX_HP_L, 32'h0000c014);
    bus_write(hmgc_pkg::IDX_HP_R, 16'h8000, 4'h3);
    settle(2);
    check_pin({20'h00000, hp_left_on, hp_right_on, hp_left_silence, hp_right_silence}, 24'h00000e);
    reg_chk(hmgc_pkg::IDX_PWR, 32'h00000003);
    // right gated by zero cross, left immediate.
    bus_write(hmgc_pkg::IDX_HP_R, 16'ha108, 4'h3);
    settle(6);
    check_pin({12'h000, hp_left_level, hp_right_level}, {12'h000, 6'h05, 6'h00});
    reg_chk(hmgc_pkg::IDX_HP_R, 32'h0000a008);
    @(posedge clk);
    hp_right_sign <= 1'b1;
    settle(10);
    check_pin({12'h000, hp_left_level, hp_right_level}, {12'h000, 6'h05, 6'h02});
    // clearing the gate releases a pending gain.
    bus_write(hmgc_pkg::IDX_HP_L, 16'he130, 4'h3);
    settle(6);
    check_pin({12'h000, hp_left_level, hp_right_level}, {12'h000, 6'h05, 6'h02});
    bus_write(hmgc_pkg::IDX_HP_L, 16'hc030, 4'h3);
    settle(2);
    check_pin({12'h000, hp_left_level, hp_right_level}, {12'h000, 6'h0c, 6'h02});
    bus_write(hmgc_pkg::IDX_OUT_CTRL, 16'h0001, 4'h3);
    settle(2);
    check_pin({23'h000000, hp_ground_feedback_enable}, 24'h000001);
    reg_chk(hmgc_pkg::IDX_OUT_CTRL, 32'h00000001);
    // An unmapped index reads zero and ignores writes.
    bus_write(8'h20, 16'hffff, 4'h3);
    reg_chk(8'h20, 32'h00000000);
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
